// ==== mfw_handler.sv ====
// Slave handler for the float parameter write functions 46h, 47h and 10h
// What this block does
// [R1] A 46h query is address, code, parameter address, four value bytes, CRC.
// [R2] A 46h answer is ten bytes echoing the query with a fresh CRC.
// [R3] The CRC goes out low byte first, high byte last.
// [R4] The answer is sent first; only then do module writes begin.
// [R5] Elevated parameters get level 2, then the write, then level 1.
// [R6] The master targets only float parameters with write level up to 2.
// [R7] Parameter addresses rise by two; at most four per command.
// [R8] A 47h query carries start address, count 00 N, byte count, values, CRC.
// [R9] A 47h answer is eight bytes: address, code, start, count, CRC.
// [R10] Multi writes answer at once, then write each parameter in turn.
// [R11] Under 10h a float spans two registers; at most eight registers.
// [R12] A 10h query carries count 00 2N, byte count 4N, values, CRC.
// [R13] A 10h answer echoes address, code, start register, count 2N, CRC.
// [R14] An accepted 10h frame runs exactly like a 47h frame.
// [R15] Bad counts or byte counts get an exception and no module writes.
module mfw_handler (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] slave_addr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    output logic mod_valid,
    output mfw_pkg::mfw_mod_cmd_t mod_cmd,
    input wire logic mod_ready,
    output logic [15:0] param_addr,
    input wire logic param_elevated
);
    typedef enum logic [1:0] {S_RX, S_CHECK, S_SEND, S_PUSH} mfw_fsm_t;
    typedef enum logic [2:0] {W_IDLE, W_LOOK, W_LVL2, W_WRITE, W_LVL1} mfw_wr_t;

    typedef struct packed {
        mfw_fsm_t fsm;
        logic [mfw_pkg::BUF_LEN-1:0][7:0] buf_b;
        logic [4:0] cnt;
        logic ovf;
        logic [15:0] crc;
        logic exc;
        logic [7:0] exc_code;
        logic [4:0] tx_len;
        logic [4:0] tx_idx;
        logic [7:0] tx_byte;
        logic [2:0] nparam;
        logic [2:0] push_idx;
        mfw_wr_t wr;
        mfw_pkg::mfw_param_t cur;
        logic elev;
        mfw_pkg::mfw_mod_cmd_t cmd;
    } mfw_handler_state_t;

    mfw_handler_state_t st;
    mfw_handler_state_t next_st;

    logic fifo_in_valid;
    logic fifo_in_ready;
    mfw_pkg::mfw_param_t fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    mfw_pkg::mfw_param_t fifo_out_data;

    // Response byte i: plain echo, or address, code with flag, exception code
    function automatic logic [7:0] mfw_payload(
        input logic [mfw_pkg::BUF_LEN-1:0][7:0] b,
        input logic exc, input logic [7:0] code, input logic [4:0] i);
        if (!exc) begin
            return b[i];
        end
        if (i == 5'h00) begin
            return b[mfw_pkg::POS_SLAVE];
        end
        if (i == 5'h01) begin
            return b[mfw_pkg::POS_FC] | mfw_pkg::EXC_FLAG;
        end
        return code;
    endfunction

    function automatic logic [31:0] mfw_value_at(
        input logic [mfw_pkg::BUF_LEN-1:0][7:0] b, input logic [4:0] base);
        return {b[base], b[base + 5'h01], b[base + 5'h02], b[base + 5'h03]};
    endfunction

    assign rx_ready = st.fsm == S_RX;
    assign tx_valid = st.fsm == S_SEND;
    assign tx_data = st.tx_byte;
    assign tx_last = tx_valid && (st.tx_idx == st.tx_len + 5'h01);
    assign fifo_in_valid = st.fsm == S_PUSH;
    assign fifo_out_ready = st.wr == W_IDLE;
    assign mod_valid = (st.wr == W_LVL2) || (st.wr == W_WRITE)
                       || (st.wr == W_LVL1);
    assign mod_cmd = st.cmd;
    assign param_addr = st.cur.addr;

    always_comb begin
        logic [7:0] fc;
        logic [7:0] n;
        logic [7:0] bc;
        logic ok;
        logic [15:0] crc_n;
        logic [4:0] idx_n;
        logic [4:0] vbase;
        next_st = st;
        fc = st.buf_b[mfw_pkg::POS_FC];
        n = 8'h00;
        bc = st.buf_b[mfw_pkg::POS_BCNT];
        ok = 1'b0;
        crc_n = st.crc;
        idx_n = st.tx_idx + 5'h01;
        vbase = mfw_pkg::MULTI_HDR + {st.push_idx, 2'b00};
        fifo_in_data.addr = {st.buf_b[mfw_pkg::POS_PA_HI],
                             st.buf_b[mfw_pkg::POS_PA_LO]}
                            + 16'(st.push_idx) * mfw_pkg::REG_STRIDE; // R7
        fifo_in_data.value = mfw_value_at(st.buf_b, vbase);
        if (fc == mfw_pkg::FC_WR_ONE) begin
            fifo_in_data.value = mfw_value_at(st.buf_b, mfw_pkg::ONE_VAL); // R1
        end
        case (st.fsm)
            S_RX: begin
                if (rx_valid) begin
                    if (st.cnt < 5'(mfw_pkg::BUF_LEN)) begin
                        next_st.buf_b[st.cnt] = rx_data;
                        next_st.cnt = st.cnt + 5'h01;
                    end else begin
                        next_st.ovf = 1'b1;
                    end
                    next_st.crc = mfw_pkg::mfw_crc_byte(st.crc, rx_data);
                    if (rx_last) begin
                        next_st.fsm = S_CHECK;
                    end
                end
            end
            S_CHECK: begin
                next_st.exc = 1'b0;
                next_st.tx_len = mfw_pkg::MULTI_ECHO; // R9 R13
                if (fc == mfw_pkg::FC_WR_MULTI) begin
                    n = st.buf_b[mfw_pkg::POS_CNT_LO]; // R8
                    ok = (bc == {n[6:0], 1'b0}) || (bc == {n[5:0], 2'b00});
                end else begin
                    n = {1'b0, st.buf_b[mfw_pkg::POS_CNT_LO][7:1]}; // R12
                    ok = !st.buf_b[mfw_pkg::POS_CNT_LO][0]
                         && (bc == {n[5:0], 2'b00});
                end
                ok = ok && st.buf_b[mfw_pkg::POS_CNT_HI] == mfw_pkg::CNT_HI
                     && n != 8'h00 && n <= mfw_pkg::MAX_PARAMS // R7 R11
                     && {3'b000, st.cnt}
                        == mfw_pkg::MULTI_FIXED + {n[5:0], 2'b00};
                next_st.nparam = n[2:0];
                if (fc == mfw_pkg::FC_WR_ONE) begin
                    ok = st.cnt == mfw_pkg::ONE_LEN; // R1
                    next_st.nparam = 3'h1;
                    next_st.tx_len = mfw_pkg::ONE_ECHO; // R2
                end
                if (!ok) begin
                    next_st.exc = 1'b1; // R15
                    next_st.exc_code = mfw_pkg::EXC_BAD_DATA;
                    next_st.tx_len = mfw_pkg::EXC_BODY;
                end
                if (fc != mfw_pkg::FC_WR_ONE && fc != mfw_pkg::FC_WR_MULTI
                    && fc != mfw_pkg::FC_WR_REGS) begin
                    next_st.exc = 1'b1;
                    next_st.exc_code = mfw_pkg::EXC_ILL_FUNC;
                    next_st.tx_len = mfw_pkg::EXC_BODY;
                end
                next_st.tx_idx = 5'h00;
                next_st.crc = mfw_pkg::CRC_INIT;
                next_st.tx_byte = mfw_payload(st.buf_b, next_st.exc,
                                              next_st.exc_code, 5'h00);
                next_st.fsm = S_SEND;
                // Wrong station, bad CRC or overlong frames are dropped
                if (st.crc != mfw_pkg::CRC_GOOD || st.ovf
                    || st.buf_b[mfw_pkg::POS_SLAVE] != slave_addr) begin
                    next_st.fsm = S_RX;
                    next_st.cnt = 5'h00;
                    next_st.ovf = 1'b0;
                end
            end
            S_SEND: begin
                if (tx_ready) begin
                    if (st.tx_idx < st.tx_len) begin
                        crc_n = mfw_pkg::mfw_crc_byte(st.crc, st.tx_byte);
                        next_st.crc = crc_n;
                    end
                    next_st.tx_idx = idx_n;
                    if (idx_n < st.tx_len) begin
                        next_st.tx_byte = mfw_payload(st.buf_b, st.exc, // R2
                                                      st.exc_code, idx_n);
                    end else if (idx_n == st.tx_len) begin
                        next_st.tx_byte = crc_n[7:0]; // R3
                    end else begin
                        next_st.tx_byte = st.crc[15:8]; // R3
                    end
                    if (tx_last) begin
                        next_st.push_idx = 3'h0;
                        next_st.fsm = st.exc ? S_RX : S_PUSH; // R4 R15
                        next_st.cnt = 5'h00;
                        next_st.ovf = 1'b0;
                        next_st.crc = mfw_pkg::CRC_INIT;
                    end
                end
            end
            S_PUSH: begin
                // Stalls here while the module side has the FIFO full
                if (fifo_in_ready) begin
                    next_st.push_idx = st.push_idx + 3'h1;
                    if (st.push_idx + 3'h1 == st.nparam) begin // R10 R14
                        next_st.fsm = S_RX;
                    end
                end
            end
            default: begin
                next_st.fsm = S_RX;
            end
        endcase

        case (st.wr)
            W_IDLE: begin
                if (fifo_out_valid) begin
                    next_st.cur = fifo_out_data;
                    next_st.wr = W_LOOK;
                end
            end
            W_LOOK: begin
                next_st.elev = param_elevated;
                next_st.cmd.addr = st.cur.addr;
                next_st.cmd.value = st.cur.value;
                next_st.cmd.op = param_elevated ? mfw_pkg::OP_LEVEL2
                                                : mfw_pkg::OP_WRITE; // R5
                next_st.wr = param_elevated ? W_LVL2 : W_WRITE;
            end
            W_LVL2: begin
                if (mod_ready) begin
                    next_st.cmd.op = mfw_pkg::OP_WRITE; // R5
                    next_st.wr = W_WRITE;
                end
            end
            W_WRITE: begin
                if (mod_ready) begin
                    next_st.cmd.op = mfw_pkg::OP_LEVEL1; // R5
                    next_st.wr = st.elev ? W_LVL1 : W_IDLE; // R10
                end
            end
            W_LVL1: begin
                if (mod_ready) begin
                    next_st.wr = W_IDLE;
                end
            end
            default: begin
                next_st.wr = W_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            st.crc <= mfw_pkg::CRC_INIT;
        end else begin
            st <= next_st;
        end
    end

    mfw_fifo #(
        .WIDTH($bits(mfw_pkg::mfw_param_t)),
        .DEPTH(mfw_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .in_valid(fifo_in_valid),
        .in_data(fifo_in_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    property p_one_len;
        @(posedge sys_clk) disable iff (!arst_n)
        (tx_last && tx_ready && !st.exc
         && st.buf_b[mfw_pkg::POS_FC] == mfw_pkg::FC_WR_ONE)
        |-> st.tx_idx == 5'h09;
    endproperty
    a_one_len: assert property (p_one_len) else $error("46h reply length"); // R2

    property p_multi_len;
        @(posedge sys_clk) disable iff (!arst_n)
        (tx_last && tx_ready && !st.exc
         && st.buf_b[mfw_pkg::POS_FC] == mfw_pkg::FC_WR_MULTI)
        |-> st.tx_idx == 5'h07;
    endproperty
    a_multi_len: assert property (p_multi_len) else $error("47h length"); // R9

    property p_regs_echo;
        @(posedge sys_clk) disable iff (!arst_n)
        (tx_last && tx_ready && !st.exc
         && st.buf_b[mfw_pkg::POS_FC] == mfw_pkg::FC_WR_REGS)
        |-> st.tx_idx == 5'h07 && st.buf_b[mfw_pkg::POS_CNT_LO][0] == 1'b0;
    endproperty
    a_regs_echo: assert property (p_regs_echo) else $error("10h reply"); // R13

    property p_echo;
        @(posedge sys_clk) disable iff (!arst_n)
        (tx_valid && !st.exc && st.tx_idx < st.tx_len)
        |-> tx_data == st.buf_b[st.tx_idx];
    endproperty
    a_echo: assert property (p_echo) else $error("Echo byte mismatch"); // R2

    property p_crc_lo;
        @(posedge sys_clk) disable iff (!arst_n)
        (tx_valid && tx_ready && st.tx_idx + 5'h01 == st.tx_len)
        |=> tx_data == st.crc[7:0] && !tx_last;
    endproperty
    a_crc_lo: assert property (p_crc_lo) else $error("CRC low not next"); // R3

    property p_crc_hi;
        @(posedge sys_clk) disable iff (!arst_n)
        tx_last |-> tx_data == st.crc[15:8];
    endproperty
    a_crc_hi: assert property (p_crc_hi) else $error("CRC high not last"); // R3

    property p_reply_first;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(fifo_in_valid) |-> $past(tx_last && tx_ready);
    endproperty
    a_reply_first: assert property (p_reply_first) else $error("Early write"); // R4

    property p_level_seq;
        @(posedge sys_clk) disable iff (!arst_n)
        (mod_valid && mod_ready && mod_cmd.op == mfw_pkg::OP_LEVEL2)
        |=> mod_valid && mod_cmd.op == mfw_pkg::OP_WRITE
            && mod_cmd.addr == $past(mod_cmd.addr);
    endproperty
    a_level_seq: assert property (p_level_seq) else $error("No write"); // R5

    property p_restore;
        @(posedge sys_clk) disable iff (!arst_n)
        (mod_valid && mod_ready && mod_cmd.op == mfw_pkg::OP_WRITE && st.elev)
        |=> mod_valid && mod_cmd.op == mfw_pkg::OP_LEVEL1;
    endproperty
    a_restore: assert property (p_restore) else $error("No level 1"); // R5

    property p_stride;
        @(posedge sys_clk) disable iff (!arst_n)
        (fifo_in_valid && fifo_in_ready && st.push_idx + 3'h1 < st.nparam)
        |=> fifo_in_data.addr == $past(fifo_in_data.addr) + 16'h0002;
    endproperty
    a_stride: assert property (p_stride) else $error("Address stride"); // R7

    property p_max_four;
        @(posedge sys_clk) disable iff (!arst_n)
        fifo_in_valid |-> st.nparam != 3'h0 && st.nparam <= 3'h4
                          && st.push_idx < st.nparam;
    endproperty
    a_max_four: assert property (p_max_four) else $error("Too many"); // R11

    property p_exc_no_write;
        @(posedge sys_clk) disable iff (!arst_n)
        (tx_last && tx_ready && st.exc) |=> st.fsm == S_RX && !fifo_in_valid;
    endproperty
    a_exc_no_write: assert property (p_exc_no_write) else $error("Exc"); // R15
endmodule

// ==== mfw_pkg.sv ====
// Constants, carrier types and shared functions of the float write handler
package mfw_pkg;
    localparam logic [7:0] FC_WR_ONE = 8'h46;
    localparam logic [7:0] FC_WR_MULTI = 8'h47;
    localparam logic [7:0] FC_WR_REGS = 8'h10;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
    localparam logic [7:0] EXC_BAD_DATA = 8'h03;
    localparam logic [7:0] CNT_HI = 8'h00;
    localparam logic [7:0] MAX_PARAMS = 8'h04;
    localparam logic [15:0] REG_STRIDE = 16'h0002;
    localparam logic [4:0] ONE_LEN = 5'h0a;
    localparam logic [7:0] MULTI_FIXED = 8'h09;
    localparam logic [4:0] MULTI_HDR = 5'h07;
    localparam logic [4:0] ONE_VAL = 5'h04;
    localparam logic [4:0] ONE_ECHO = 5'h08;
    localparam logic [4:0] MULTI_ECHO = 5'h06;
    localparam logic [4:0] EXC_BODY = 5'h03;
    localparam int BUF_LEN = 25;
    localparam int POS_SLAVE = 0;
    localparam int POS_FC = 1;
    localparam int POS_PA_HI = 2;
    localparam int POS_PA_LO = 3;
    localparam int POS_CNT_HI = 4;
    localparam int POS_CNT_LO = 5;
    localparam int POS_BCNT = 6;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_GOOD = 16'h0000;
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [1:0] {OP_LEVEL2, OP_WRITE, OP_LEVEL1} mfw_op_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] value;
    } mfw_param_t;

    typedef struct packed {
        mfw_op_t op;
        logic [15:0] addr;
        logic [31:0] value;
    } mfw_mod_cmd_t;

    // One byte step of the reflected Modbus CRC16
    function automatic logic [15:0] mfw_crc_byte(input logic [15:0] c,
                                                 input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
endpackage

// ==== mfw_fifo.sv ====
// Small valid/ready FIFO holding parameter writes for the module side
module mfw_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } mfw_fifo_state_t;

    mfw_fifo_state_t st;
    mfw_fifo_state_t next_st;
    logic push;
    logic pop;

    assign in_ready = st.cnt != FULL;
    assign out_valid = st.cnt != '0;
    assign out_data = st.mem[st.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = (st.wp == LAST) ? '0 : st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = (st.rp == LAST) ? '0 : st.rp + 1'b1;
        end
        if (push && !pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ==== mfw_mod_model.sv ====
// Module-side partner: takes module commands, logs them, answers level lookups
module mfw_mod_model (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic slow,
    input wire logic mod_valid,
    input wire mfw_pkg::mfw_mod_cmd_t mod_cmd,
    output logic mod_ready,
    input wire logic [15:0] param_addr,
    output logic param_elevated
);
    timeunit 1ns;
    timeprecision 1ns;
    mfw_pkg::mfw_mod_cmd_t logq[$];
    logic phase;
    // Parameters with address bit 8 set are configured for write level 2
    assign param_elevated = param_addr[8];
    // Slow mode accepts on every other cycle only
    assign mod_ready = !slow || phase;
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
            if (mod_valid && mod_ready) begin
                logq.push_back(mod_cmd);
            end
        end
    end
endmodule

// ==== mfw_handler_bench.sv ====
// Self-checking bench of the float write handler
module mfw_handler_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] ME = 8'h11;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic rx_last = 1'b0;
    logic tx_ready = 1'b1;
    logic slow = 1'b0;
    logic rx_ready, tx_valid, tx_last, mod_valid, mod_ready, param_elevated;
    logic [7:0] tx_data;
    logic [15:0] param_addr;
    mfw_pkg::mfw_mod_cmd_t mod_cmd;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [7:0] fr[$];
    logic [7:0] er[$];
    mfw_pkg::mfw_mod_cmd_t ec[$];

    mfw_handler mfw_handler_i (.sys_clk(sys_clk), .arst_n(arst_n),
        .slave_addr(ME), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
        .mod_valid(mod_valid), .mod_cmd(mod_cmd), .mod_ready(mod_ready),
        .param_addr(param_addr), .param_elevated(param_elevated));
    mfw_mod_model mfw_mod_model_i (.sys_clk(sys_clk), .arst_n(arst_n),
        .slow(slow), .mod_valid(mod_valid), .mod_cmd(mod_cmd),
        .mod_ready(mod_ready), .param_addr(param_addr),
        .param_elevated(param_elevated));

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Reflected CRC16, initial value all ones, appended low byte first
    task automatic add_crc(ref logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
            end
        end
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
    endtask

    function automatic logic [31:0] val(input int j);
        return {8'h40 + 8'(j), 8'ha5, 8'h5a, 8'h0f + 8'(j)};
    endfunction

    // Expected module traffic of one parameter
    task automatic exp_param(input logic [15:0] a, input logic [31:0] v);
        if (a[8]) begin
            ec.push_back({mfw_pkg::OP_LEVEL2, a, v});
        end
        ec.push_back({mfw_pkg::OP_WRITE, a, v});
        if (a[8]) begin
            ec.push_back({mfw_pkg::OP_LEVEL1, a, v});
        end
    endtask

    task automatic send_frame();
        foreach (fr[i]) begin
            rx_valid = 1'b1;
            rx_data = fr[i];
            rx_last = (i == fr.size() - 1);
            @(negedge sys_clk);
            for (int t = 0; t < 200 && rx_ready !== 1'b1; t++) begin
                @(negedge sys_clk);
            end
            @(posedge sys_clk);
            #1;
        end
        rx_valid = 1'b0;
        rx_last = 1'b0;
        chk("rx_ready after frame", 0, rx_ready);
    endtask

    task automatic get_resp(input bit stall);
        foreach (er[i]) begin
            if (stall) begin
                tx_ready = 1'b0;
                @(posedge sys_clk);
                #1;
                tx_ready = 1'b1;
            end
            @(negedge sys_clk);
            for (int t = 0; t < 50 && tx_valid !== 1'b1; t++) begin
                @(negedge sys_clk);
            end
            chk("tx_data", er[i], tx_data);
            chk("tx_last", (i == er.size() - 1), tx_last);
            chk("mod_valid in reply", 0, mod_valid);
            @(posedge sys_clk);
            #1;
        end
        chk("writes before reply end", 0, mfw_mod_model_i.logq.size());
    endtask

    task automatic run(input bit stall);
        mfw_mod_model_i.logq.delete();
        add_crc(fr);
        send_frame();
        get_resp(stall);
        for (int t = 0; t < 600; t++) begin
            if (mfw_mod_model_i.logq.size() >= ec.size()) break;
            @(posedge sys_clk);
        end
        repeat (30) @(posedge sys_clk);
        #1;
        chk("module command count", ec.size(),
            mfw_mod_model_i.logq.size());
        if (ec.size() > 0) begin
            chk("param_addr", ec[ec.size() - 1].addr, param_addr);
        end
        foreach (ec[i]) begin
            if (i < mfw_mod_model_i.logq.size()) begin
                chk("op", ec[i].op, mfw_mod_model_i.logq[i].op);
                if (ec[i].op == mfw_pkg::OP_WRITE) begin
                    chk("write", ec[i], mfw_mod_model_i.logq[i]);
                end
            end
        end
    endtask

    task automatic t_single(input logic [15:0] a, input bit stall);
        logic [31:0] v;
        v = val(7);
        fr = {ME, 8'h46, a[15:8], a[7:0], v[31:24], v[23:16], v[15:8], v[7:0]};
        er = fr;
        add_crc(er);
        ec.delete();
        exp_param(a, v);
        run(stall);
    endtask

    task automatic t_multi(input logic [7:0] fc, input logic [15:0] a,
                           input int n, input bit stall);
        logic [31:0] v;
        logic [7:0] cnt;
        cnt = (fc == 8'h10) ? 8'(2 * n) : 8'(n);
        fr = {ME, fc, a[15:8], a[7:0], 8'h00, cnt};
        er = fr;
        add_crc(er);
        fr.push_back((fc == 8'h10) ? 8'(4 * n) : 8'(2 * n));
        ec.delete();
        for (int j = 0; j < n; j++) begin
            v = val(j);
            fr = {fr, v[31:24], v[23:16], v[15:8], v[7:0]};
            exp_param(a + 16'(2 * j), v);
        end
        run(stall);
    endtask

    task automatic t_exc(input logic [7:0] code);
        er = {ME, fr[1] | 8'h80, code};
        add_crc(er);
        ec.delete();
        run(1'b0);
    endtask

    task automatic t_drop(input bit bad_crc);
        bit seen;
        fr = {bad_crc ? ME : 8'h12, 8'h46, 8'h00, 8'h20,
              8'h01, 8'h02, 8'h03, 8'h04};
        add_crc(fr);
        if (bad_crc) begin
            fr[9] = fr[9] ^ 8'h01;
        end
        send_frame();
        seen = 1'b0;
        repeat (20) begin
            @(negedge sys_clk);
            if (tx_valid !== 1'b0) seen = 1'b1;
        end
        chk("reply to dropped frame", 0, seen);
        @(posedge sys_clk);
        #1;
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
        @(posedge sys_clk);
        #1;
        t_single(16'h0020, 1'b0);
        t_single(16'h0130, 1'b1);
        slow = 1'b1;
        t_multi(8'h47, 16'h00fe, 4, 1'b0);
        t_multi(8'h10, 16'h0200, 2, 1'b1);
        slow = 1'b0;
        t_multi(8'h10, 16'h0040, 4, 1'b0);
        t_multi(8'h47, 16'h0050, 1, 1'b0);
        fr = {ME, 8'h47, 8'h00, 8'h10, 8'h00, 8'h05, 8'h0a};
        t_exc(8'h03);
        fr = {ME, 8'h47, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
        t_exc(8'h03);
        fr = {ME, 8'h10, 8'h00, 8'h10, 8'h01, 8'h02, 8'h04,
              8'h01, 8'h02, 8'h03, 8'h04};
        t_exc(8'h03);
        fr = {ME, 8'h03, 8'h00, 8'h10, 8'h00, 8'h01};
        t_exc(8'h01);
        t_drop(1'b0);
        t_drop(1'b1);
        t_single(16'h0024, 1'b0);
        end_of_test();
    end
endmodule
